// ==== verilog/sdr_consts.svh ====
/*
 * Constants of the serial byte buffer: register address, reset values,
 * field positions and the byte and buffer sizes.
 * Assumes it is included by bare name from design files.
 */
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

`define SDR_ADDR_BYTE_BUFFER 8'hc2
`define SDR_RESET_BYTE 8'h00
`define SDR_RESET_READ 8'h00
`define SDR_BYTE_MSB 7
`define SDR_LAST_BIT 3'h7
`define SDR_FIRST_BIT 3'h0
`define SDR_FIFO_WIDTH 8
`define SDR_FIFO_DEPTH 32
`define SDR_FIFO_ADDR_W 5

`endif

// ==== verilog/sdr_pkg.sv ====
/*
 * Types shared by the serial byte buffer, its port monitor and its test bench.
 * Assumes the constants header is on the include path.
 */
`include "sdr_consts.svh"

package sdr_pkg;

    // special-function register access from the cpu
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sdr_sfr_req_t;

    // steering from the bus state machine and control register
    typedef struct packed {
        logic enable;
        logic tx_active;
        logic bit_sample;
        logic step_done;
        logic event_clear;
    } sdr_shift_ctl_t;

    typedef enum logic [1:0] {
        SDR_SH_IDLE = 2'b00,
        SDR_SH_SHIFT = 2'b01,
        SDR_SH_PUSH = 2'b10
    } sdr_shift_state_t;

endpackage : sdr_pkg

// ==== verilog/sdr_fifo.sv ====
/*
 * Receive FIFO with a registered output stage; total capacity is DEPTH.
 * Assumes one clock, asynchronous active-high reset, valid/ready on both
 * sides with a transfer on valid and ready in the same cycle.
 */
`timescale 1ns/1ps
`include "sdr_consts.svh"

module sdr_fifo #(
    parameter int WIDTH = `SDR_FIFO_WIDTH,
    parameter int DEPTH = `SDR_FIFO_DEPTH,
    parameter int AW = `SDR_FIFO_ADDR_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // filling side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // draining side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic [WIDTH-1:0] out_reg, out_next;
    logic out_valid_reg, out_valid_next;
    logic [AW:0] total;
    logic push;
    logic take;
    logic load;

    always_comb begin
        // output stage counts toward capacity, so full is honest
        total = count_reg + {{AW{1'b0}}, out_valid_reg};
        in_ready_out = (total < DEPTH[AW:0]);
        push = in_valid_in && in_ready_out;
        take = out_valid_reg && out_ready_in;
        load = (count_reg != '0) && (!out_valid_reg || take);
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        out_next = load ? mem_reg[rd_ptr_reg] : out_reg;
        out_valid_next = load || (out_valid_reg && !take);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            out_reg <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end

    // storage carries no reset; only words counted valid are ever read
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    assign out_data_out = out_reg;
    assign out_valid_out = out_valid_reg;

endmodule // sdr_fifo

// ==== verilog/sdr_top.sv ====
/*
 * Serial byte buffer of a two-wire bus interface: cpu register at its
 * special-function address, msb-first shift path, serial event flag and
 * a receive FIFO that keeps every completed byte.
 * Assumes bit_sample pulses come from the bus state machine on this clock
 * at each data-line sample point, two cycles after the level settled, and
 * that the bus machine stretches the clock while bus_stall_out is high.
 */
// Contract
// (RULE1) register holds still, no shifting, while the event flag is set
// (RULE2) cpu reads and writes work while the flag is set
// (RULE3) software leaves the register alone when enabled and flag clear
// (RULE4) transmit sends the register msb first down to lsb
// (RULE5) first received bit ends up in the msb
// (RULE6) every transmit bit also shifts the sampled line level in
// (RULE7) after a byte the register holds what was really on the bus
// (RULE8) lost arbitration leaves the correct received byte in place
// (RULE9) eight-bit read/write register at 0xc2, zero after reset
// (RULE10) flag sets on byte or bus step done, stays until software clears
`timescale 1ns/1ps
`include "sdr_consts.svh"

module sdr_top
    import sdr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // special-function register port
    input wire sdr_sfr_req_t sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    // control from the bus state machine and control register
    input wire sdr_shift_ctl_t shift_ctl_in,
    output logic event_flag_out,
    output logic bus_stall_out,
    // data line, open drain
    input wire logic sda_pin_in,
    output logic sda_drive_out,
    output logic sda_oe_out,
    // received byte stream
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in
);

    function automatic logic sfr_hit(input sdr_sfr_req_t req);
        sfr_hit = (req.addr == `SDR_ADDR_BYTE_BUFFER);
    endfunction

    // data line synchroniser
    logic sda_meta_reg, sda_meta_next;
    logic sda_sync_reg, sda_sync_next;

    always_comb begin
        sda_meta_next = sda_pin_in;
        sda_sync_next = sda_meta_reg;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else begin
            sda_meta_reg <= sda_meta_next;
            sda_sync_reg <= sda_sync_next;
        end
    end

    // shift path and event flag
    sdr_shift_state_t state_reg, state_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic flag_reg, flag_next;
    logic byte_done;
    logic fifo_in_ready;
    logic wr_ok;

    always_comb begin
        state_next = state_reg;
        data_next = data_reg;
        bit_cnt_next = bit_cnt_reg;
        byte_done = 1'b0;
        // writes land only while nothing can be shifting
        wr_ok = sfr_req_in.wr && sfr_hit(sfr_req_in)
            && (flag_reg || !shift_ctl_in.enable); // see (RULE2) (RULE3)
        if (wr_ok) begin
            data_next = sfr_req_in.wdata; // see (RULE9)
        end
        unique case (state_reg)
            SDR_SH_IDLE: begin
                bit_cnt_next = `SDR_FIRST_BIT;
                if (shift_ctl_in.enable && !flag_reg) begin
                    state_next = SDR_SH_SHIFT;
                end
            end
            SDR_SH_SHIFT: begin
                if (!shift_ctl_in.enable || flag_reg) begin
                    state_next = SDR_SH_IDLE; // see (RULE1)
                    bit_cnt_next = `SDR_FIRST_BIT;
                end else if (shift_ctl_in.bit_sample) begin
                    // one shift serves both directions: the level read
                    // back replaces the bit just driven
                    data_next = {data_reg[6:0], sda_sync_reg}; // see (RULE4) (RULE5) (RULE6)
                    if (bit_cnt_reg == `SDR_LAST_BIT) begin
                        state_next = SDR_SH_PUSH; // see (RULE7) (RULE8)
                        bit_cnt_next = `SDR_FIRST_BIT;
                    end else begin
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                    end
                end
            end
            SDR_SH_PUSH: begin
                // flag waits for room, so a full FIFO stalls the bus
                if (fifo_in_ready) begin
                    byte_done = 1'b1;
                    state_next = SDR_SH_IDLE;
                end
            end
            default: begin
                state_next = SDR_SH_IDLE;
                bit_cnt_next = `SDR_FIRST_BIT;
            end
        endcase
        // a set arriving with the clear wins
        flag_next = flag_reg;
        if (shift_ctl_in.event_clear) begin
            flag_next = 1'b0;
        end
        if (byte_done || shift_ctl_in.step_done) begin
            flag_next = 1'b1; // see (RULE10)
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SDR_SH_IDLE;
            data_reg <= `SDR_RESET_BYTE; // see (RULE9)
            bit_cnt_reg <= `SDR_FIRST_BIT;
            flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
            bit_cnt_reg <= bit_cnt_next;
            flag_reg <= flag_next;
        end
    end

    // registered outputs: read data, pin, stall
    logic [7:0] rdata_reg, rdata_next;
    logic sda_oe_reg, sda_oe_next;
    logic stall_reg, stall_next;

    always_comb begin
        rdata_next = `SDR_RESET_READ;
        if (sfr_req_in.rd && sfr_hit(sfr_req_in)) begin
            rdata_next = data_reg; // see (RULE2) (RULE9)
        end
        // open drain: pull low for a zero msb, release for a one
        sda_oe_next = shift_ctl_in.enable && shift_ctl_in.tx_active
            && (state_next == SDR_SH_SHIFT)
            && !data_next[`SDR_BYTE_MSB]; // see (RULE4)
        stall_next = (state_next == SDR_SH_PUSH);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= `SDR_RESET_READ;
            sda_oe_reg <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            sda_oe_reg <= sda_oe_next;
            stall_reg <= stall_next;
        end
    end

    sdr_fifo #(
        .WIDTH(`SDR_FIFO_WIDTH),
        .DEPTH(`SDR_FIFO_DEPTH),
        .AW(`SDR_FIFO_ADDR_W)
    ) u_rx_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_data_in(data_reg),
        .in_valid_in(state_reg == SDR_SH_PUSH),
        .in_ready_out(fifo_in_ready),
        .out_data_out(rx_byte_out),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in)
    );

    assign sfr_rdata_out = rdata_reg;
    assign event_flag_out = flag_reg;
    assign bus_stall_out = stall_reg;
    assign sda_oe_out = sda_oe_reg;
    // the pin is only ever pulled low
    assign sda_drive_out = 1'b0;

endmodule // sdr_top

// ==== bench/sdr_monitor.sv ====
/* port checker for sdr_top.
   assumes one clock domain; bound to sdr_top below. */
`timescale 1ns/1ps
module sdr_monitor
    import sdr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // watched ports
    input wire sdr_sfr_req_t sfr_req_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire sdr_shift_ctl_t shift_ctl_in,
    input wire logic event_flag_out,
    input wire logic bus_stall_out,
    input wire logic sda_drive_out,
    input wire logic sda_oe_out,
    input wire logic [7:0] rx_byte_out,
    input wire logic rx_valid_out,
    input wire logic rx_ready_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rd_miss_a: assert property (!sfr_req_in.rd ||
        sfr_req_in.addr != 8'hc2 |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero");
    flag_hold_a: assert property (event_flag_out &&
        !shift_ctl_in.event_clear |=> event_flag_out)
        else $error("flag dropped");
    flag_clear_a: assert property (event_flag_out &&
        shift_ctl_in.event_clear && !shift_ctl_in.step_done &&
        !bus_stall_out
        |=> !event_flag_out) else $error("flag not cleared");
    step_set_a: assert property (shift_ctl_in.step_done
        |=> event_flag_out) else $error("flag not set");
    stall_push_a: assert property ($fell(bus_stall_out)
        |-> event_flag_out) else $error("push without flag");
    oe_frozen_a: assert property (event_flag_out &&
        $past(event_flag_out) && $past(event_flag_out, 2) &&
        !$past(sfr_req_in.wr) && $stable(shift_ctl_in.tx_active)
        |-> $stable(sda_oe_out)) else $error("shift while flag set");
    rx_hold_a: assert property (rx_valid_out && !rx_ready_in
        |=> rx_valid_out && $stable(rx_byte_out))
        else $error("rx byte not held");
    drive_low_a: assert property (sda_drive_out == 1'b0)
        else $error("data line driven high");
endmodule // sdr_monitor

bind sdr_top sdr_monitor u_mon (.clk_in(clk_in), .rst_in(rst_in),
    .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
    .shift_ctl_in(shift_ctl_in), .event_flag_out(event_flag_out),
    .bus_stall_out(bus_stall_out), .sda_drive_out(sda_drive_out),
    .sda_oe_out(sda_oe_out), .rx_byte_out(rx_byte_out),
    .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in));

// ==== bench/sdr_bus_model.sv ====
/* other party on the data line: open drain plus pull-up.
   assumes the bench steers pull_low_in per bit. */
`timescale 1ns/1ps
module sdr_bus_model (
    // line drivers
    input wire logic dut_oe_in,
    input wire logic pull_low_in,
    // resolved line
    output logic sda_line_out
);
    // wired-and: a released line reads high, any puller wins
    assign sda_line_out = ~(dut_oe_in | pull_low_in);
endmodule // sdr_bus_model

// ==== bench/sdr_top_test.sv ====
/* self-checking bench for sdr_top: register access, byte shifting
   against another bus party, fifo fill, stall and drain.
   assumes sdr_bus_model resolves the data line. */
`timescale 1ns/1ps
module sdr_top_test;
    import sdr_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    sdr_sfr_req_t req = '0;
    sdr_shift_ctl_t ctl = '0;
    logic rx_ready = 1'b0;
    logic pull = 1'b0;
    logic rd_pend = 1'b0;
    logic sda, oe, drv, flag, stall, rxv;
    logic [7:0] rdata, rxb;
    logic [7:0] rq[$];
    logic [7:0] xq[$];
    int fail_count = 0;
    int cmp_count = 0;

    sdr_top dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_req_in(req),
        .sfr_rdata_out(rdata), .shift_ctl_in(ctl), .event_flag_out(flag),
        .bus_stall_out(stall), .sda_pin_in(sda), .sda_drive_out(drv),
        .sda_oe_out(oe), .rx_byte_out(rxb), .rx_valid_out(rxv),
        .rx_ready_in(rx_ready));
    sdr_bus_model other (.dut_oe_in(oe), .pull_low_in(pull),
        .sda_line_out(sda));

    initial forever #5 clk_in = ~clk_in;

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic sfr(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk_in);
        req <= '0;
    endtask

    // one byte: load while flagged, release, shift eight bits
    task automatic xfer(input logic [7:0] tx, input logic [7:0] ot,
        input logic rx);
        // a receiving end never pulls, so the line carries only ot
        logic [7:0] m;
        m = tx | {8{rx}};
        @(posedge clk_in);
        ctl.tx_active <= !rx;
        ctl.step_done <= 1'b1;
        @(posedge clk_in);
        ctl.step_done <= 1'b0;
        sfr(1'b1, 8'hc2, tx);
        rq.push_back(tx);
        sfr(1'b0, 8'hc2, 8'h00);
        @(posedge clk_in);
        ctl.event_clear <= 1'b1;
        @(posedge clk_in);
        ctl.event_clear <= 1'b0;
        cyc(2);
        // refused while shifting, so the byte on the wire stays tx
        sfr(1'b1, 8'hc2, ~tx);
        for (int b = 7; b >= 0; b--) begin
            pull <= !ot[b];
            cyc(3);
            chk("line", {7'h00, m[b] & ot[b]}, {7'h00, sda});
            ctl.bit_sample <= 1'b1;
            @(posedge clk_in);
            ctl.bit_sample <= 1'b0;
        end
        pull <= 1'b0;
        xq.push_back(m & ot);
    endtask

    always @(negedge clk_in) begin
        if (rd_pend)
            chk("sfr_rdata", rq.pop_front(), rdata);
        rd_pend = req.rd;
        if (rxv && rx_ready && xq.size() > 0)
            chk("rx_byte", xq.pop_front(), rxb);
    end

    initial begin
        void'($urandom(32'hf385));
        cyc(2);
        rst_in <= 1'b0;
        rq.push_back(8'h00);
        sfr(1'b0, 8'hc2, 8'h00);
        rq.push_back(8'h00);
        sfr(1'b0, 8'hc3, 8'h00);
        ctl.enable <= 1'b1;
        ctl.tx_active <= 1'b1;
        for (int i = 0; i < 33; i++) begin
            logic [7:0] t;
            logic [7:0] o;
            logic r;
            r = (i % 4 == 1);
            t = 8'($urandom);
            o = (i % 4 == 3 || r) ? 8'($urandom) : 8'hff;
            xfer(t, o, r);
            for (int n = 0; n < 9 && flag !== 1'b1; n++) cyc(1);
            chk("flag", {7'h00, i < 32}, {7'h00, flag});
            chk("stall", {7'h00, i == 32}, {7'h00, stall});
            if (i < 32) begin
                ctl.bit_sample <= 1'b1;
                cyc(1);
                ctl.bit_sample <= 1'b0;
                rq.push_back((t | {8{r}}) & o);
                sfr(1'b0, 8'hc2, 8'h00);
            end
        end
        // consumer stalls at random while the fifo drains
        for (int n = 0; n < 400 && xq.size() > 0; n++) begin
            rx_ready <= 1'($urandom);
            cyc(1);
        end
        cyc(2);
        chk("rx_valid", 8'h00, {7'h00, rxv});
        chk("left", 8'h00, 8'(xq.size()));
        chk("flag", 8'h01, {7'h00, flag});
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule // sdr_top_test
